// [src/gph_pkg.sv]
// Package of offsets, field layouts and fixed values for the configuration header tail.
package gph_pkg;

    // Bus geometry
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [9:0] SUBSYS_VENDOR_IDX = 10'h02c;
    localparam logic [9:0] SUBSYS_CODE_IDX   = 10'h02e;
    localparam logic [9:0] ROM_BASE_IDX      = 10'h030;
    localparam logic [9:0] CAP_HEAD_IDX      = 10'h034;
    localparam logic [9:0] IRQ_ROUTE_IDX     = 10'h03c;
    localparam logic [9:0] IRQ_PIN_IDX       = 10'h03d;
    localparam logic [9:0] MIN_GRANT_IDX     = 10'h03e;
    localparam logic [9:0] MAX_LAT_IDX       = 10'h03f;
    localparam logic [9:0] PM_HEADER_IDX     = 10'h0dc;
    localparam logic [9:0] PM_WORD_IDX       = 10'h0de;

    // Reset and fixed values
    localparam logic [15:0] SUBSYS_RESET    = 16'h0000;
    localparam logic [31:0] ROM_BASE_VALUE  = 32'h00000000;
    localparam logic [7:0]  CAP_HEAD_VALUE  = 8'hdc;
    localparam logic [7:0]  IRQ_ROUTE_RESET = 8'h00;
    localparam logic [7:0]  IRQ_PIN_VALUE   = 8'h01;
    localparam logic [7:0]  MIN_GRANT_VALUE = 8'h00;
    localparam logic [7:0]  MAX_LAT_VALUE   = 8'h00;

    // Capability header fields
    localparam logic [7:0]  PM_NEXT_LINK    = 8'h00;
    localparam logic [7:0]  PM_KIND_CODE    = 8'h01;

    // Capability word fields
    localparam int          PM_DSI_POS      = 5;
    localparam logic [2:0]  PM_VERSION      = 3'b001;
    localparam logic [15:0] PM_WORD_RESET   = 16'h0021;

    // Responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

// [src/gph_config_tail.sv]
// Configuration header tail register bank behind an AXI4-Lite slave.
`timescale 1ns/1ps
// Notes on behaviour
// - Subsystem code word resets zero, write once
// - Subsystem vendor word resets zero, write once
// - Only reset clears write-once words and locks
// - Expansion ROM base reads zero, ignores writes
// - ROM enable and bits 10:1 zero
// - ROM mask bits 17:11 read zero
// - Capability list head reads fixed DCh
// - Interrupt routing byte stores written value
// - Interrupt pin byte reads 01h
// - Minimum grant byte reads zero
// - Maximum latency byte reads zero
// - Capability header link field reads 00h
// - Capability header kind code reads 01h
// - Event support bits 15:11 read zero
// - D2 and D1 support bits read zero
// - Device specific init bit reads one
// - Aux power and event clock zero
// - Version 001b, reserved zero, word 0021h
module gph_config_tail
    import gph_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Write address channel
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // Write data channel
    input  wire logic [DATA_WIDTH-1:0]   s_axi_wdata,
    input  wire logic [DATA_WIDTH/8-1:0] s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // Write response channel
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // Read address channel
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // Read data channel
    output logic [DATA_WIDTH-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    logic                      awready_reg;
    logic                      wready_reg;
    logic                      bvalid_reg;
    logic [1:0]                bresp_reg;
    logic                      arready_reg;
    logic                      rvalid_reg;
    logic [1:0]                rresp_reg;
    logic [DATA_WIDTH-1:0]     rdata_reg;

    logic                      aw_full_reg;
    logic                      w_full_reg;
    logic [9:0]                aw_idx_reg;
    logic [DATA_WIDTH-1:0]     wdata_reg;
    logic [DATA_WIDTH/8-1:0]   wstrb_reg;

    // Write-once words, their locks and the interrupt routing byte
    logic [15:0]               subsys_vendor_reg;
    logic                      vendor_locked_reg;
    logic [15:0]               subsys_code_reg;
    logic                      code_locked_reg;
    logic [7:0]                irq_route_reg;

    // Handshake and decode nets
    logic                      aw_take;
    logic                      w_take;
    logic                      ar_take;
    logic                      do_write;
    logic                      low_half_strobed;
    logic                      wr_hit;
    logic                      rd_hit;
    logic [DATA_WIDTH-1:0]     rd_data;
    logic [15:0]               pm_header;
    logic [15:0]               pm_word;
    logic [DATA_WIDTH-1:0]     rom_base;
    logic [9:0]                ar_idx;
    logic                      wr_vendor_sel;
    logic                      wr_code_sel;
    logic                      wr_route_sel;

    assign aw_take = s_axi_awvalid && awready_reg;
    assign w_take  = s_axi_wvalid && wready_reg;
    assign ar_take = s_axi_arvalid && arready_reg;
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign low_half_strobed = |wstrb_reg[1:0];

    // Read index taken straight off the bus
    assign ar_idx = s_axi_araddr[ADDR_WIDTH-1:2];

    // Write selects; a locked word still answers okay
    assign wr_vendor_sel = do_write && aw_idx_reg == SUBSYS_VENDOR_IDX;
    assign wr_code_sel   = do_write && aw_idx_reg == SUBSYS_CODE_IDX;
    assign wr_route_sel  = do_write && aw_idx_reg == IRQ_ROUTE_IDX;

    // Last entry of the capability list
    always_comb
    begin
        pm_header[15:8] = PM_NEXT_LINK;
        pm_header[7:0]  = PM_KIND_CODE;
    end

    // Every field spelled out so a stray bit cannot hide
    always_comb
    begin
        pm_word = 16'h0000;
        pm_word[15:11] = 5'b00000;
        pm_word[10] = 1'b0;
        pm_word[9]  = 1'b0;
        pm_word[8:6] = 3'b000;
        pm_word[PM_DSI_POS] = 1'b1;
        pm_word[4] = 1'b0;
        pm_word[3] = 1'b0;
        pm_word[2:0] = PM_VERSION;
    end

    // No separate ROM, so every field is tied off
    always_comb
    begin
        rom_base = ROM_BASE_VALUE;
        rom_base[31:18] = 14'h0000;
        rom_base[17:11] = 7'h00;
        rom_base[10:1] = 10'h000;
        rom_base[0]    = 1'b0;
    end

    // Write address capture; held until the write is performed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_reg <= 1'b0;
            aw_idx_reg  <= 10'h000;
            awready_reg <= 1'b1;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[ADDR_WIDTH-1:2];
                awready_reg <= 1'b0;
            end
            else if (do_write)
            begin
                aw_full_reg <= 1'b0;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                awready_reg <= 1'b1;
            end
        end
    end

    // Write data capture; either channel may arrive first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_full_reg <= 1'b0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
            wready_reg <= 1'b1;
        end
        else
        begin
            if (w_take)
            begin
                w_full_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            else if (do_write)
            begin
                w_full_reg <= 1'b0;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                wready_reg <= 1'b1;
            end
        end
    end

    // Address decode for writes; read-only words still count as mapped
    always_comb
    begin
        if (aw_idx_reg == SUBSYS_VENDOR_IDX || aw_idx_reg == SUBSYS_CODE_IDX)
            wr_hit = 1'b1;
        else if (aw_idx_reg == ROM_BASE_IDX || aw_idx_reg == CAP_HEAD_IDX)
            wr_hit = 1'b1;
        else if (aw_idx_reg >= IRQ_ROUTE_IDX && aw_idx_reg <= MAX_LAT_IDX)
            wr_hit = 1'b1;
        else if (aw_idx_reg == PM_HEADER_IDX || aw_idx_reg == PM_WORD_IDX)
            wr_hit = 1'b1;
        else
            wr_hit = 1'b0;
    end

    // Write response
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else
        begin
            if (do_write)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Subsystem vendor word; lock survives everything but reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            subsys_vendor_reg <= SUBSYS_RESET;
            vendor_locked_reg <= 1'b0;
        end
        else if (wr_vendor_sel && !vendor_locked_reg && low_half_strobed)
        begin
            if (wstrb_reg[0])
                subsys_vendor_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1])
                subsys_vendor_reg[15:8] <= wdata_reg[15:8];
            vendor_locked_reg <= 1'b1;
        end
    end

    // Subsystem code word
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            subsys_code_reg <= SUBSYS_RESET;
            code_locked_reg <= 1'b0;
        end
        else if (wr_code_sel && !code_locked_reg && low_half_strobed)
        begin
            if (wstrb_reg[0])
                subsys_code_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1])
                subsys_code_reg[15:8] <= wdata_reg[15:8];
            code_locked_reg <= 1'b1;
        end
    end

    // Interrupt routing byte; storage only, drives nothing else
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_route_reg <= IRQ_ROUTE_RESET;
        else if (wr_route_sel && wstrb_reg[0])
            irq_route_reg <= wdata_reg[7:0];
    end

    // Read decode; narrow words sit in the low bits
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = 32'h00000000;
        if (ar_idx == SUBSYS_VENDOR_IDX)
            rd_data = {16'h0000, subsys_vendor_reg};
        else if (ar_idx == SUBSYS_CODE_IDX)
            rd_data = {16'h0000, subsys_code_reg};
        else if (ar_idx == ROM_BASE_IDX)
            rd_data = rom_base;
        else if (ar_idx == CAP_HEAD_IDX)
            rd_data = {24'h000000, CAP_HEAD_VALUE};
        else if (ar_idx == IRQ_ROUTE_IDX)
            rd_data = {24'h000000, irq_route_reg};
        else if (ar_idx == IRQ_PIN_IDX)
            rd_data = {24'h000000, IRQ_PIN_VALUE};
        else if (ar_idx == MIN_GRANT_IDX)
            rd_data = {24'h000000, MIN_GRANT_VALUE};
        else if (ar_idx == MAX_LAT_IDX)
            rd_data = {24'h000000, MAX_LAT_VALUE};
        else if (ar_idx == PM_HEADER_IDX)
            rd_data = {16'h0000, pm_header};
        else if (ar_idx == PM_WORD_IDX)
            rd_data = {16'h0000, pm_word};
        else
            rd_hit = 1'b0;
    end

    // Read address ready; one read in flight at a time
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            arready_reg <= 1'b1;
        else if (ar_take)
            arready_reg <= 1'b0;
        else if (rvalid_reg && s_axi_rready)
            arready_reg <= 1'b1;
    end

    // Read valid; stands until the master takes it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rvalid_reg <= 1'b0;
        else if (ar_take)
            rvalid_reg <= 1'b1;
        else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // Read data; address decoded in the cycle it is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end
        else if (ar_take)
        begin
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= rd_data;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

endmodule

// [test/gph_config_tail_asserts.sv]
// Checker of fixed register values and write responses at the bus ports
`timescale 1ns/1ps
module gph_config_tail_asserts
    import gph_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // Write side
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    // Read side
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [DATA_WIDTH-1:0] s_axi_rdata,
    input wire logic                  s_axi_rvalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Answer lands one cycle after the address is taken
    property rd_val(logic [ADDR_WIDTH-1:0] a, logic [DATA_WIDTH-1:0] v);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a |=> s_axi_rvalid && s_axi_rdata == v;
    endproperty
    rom_base_zero_a: assert property (rd_val(12'h0c0, 32'h0)) else $error("rom base nonzero");
    cap_head_a: assert property (rd_val(12'h0d0, 32'hdc)) else $error("list head wrong");
    irq_pin_a: assert property (rd_val(12'h0f4, 32'h1)) else $error("pin byte wrong");
    min_grant_a: assert property (rd_val(12'h0f8, 32'h0)) else $error("grant byte nonzero");
    max_lat_a: assert property (rd_val(12'h0fc, 32'h0)) else $error("latency byte nonzero");
    pm_header_a: assert property (rd_val(12'h370, 32'h1)) else $error("pm header wrong");
    pm_word_a: assert property (rd_val(12'h378, 32'h21)) else $error("pm word wrong");
    ro_write_ok_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 12'h0c0 |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY) else $error("ro write not okay");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// [test/gph_axi_master.sv]
// Host configuration master model on the register bus
`timescale 1ns/1ps
module gph_axi_master
    import gph_pkg::*;
(
    // Clock
    input wire logic                  clk,
    // Write channels
    output logic [ADDR_WIDTH-1:0]     s_axi_awaddr = '0,
    output logic                      s_axi_awvalid = 1'b0,
    input wire logic                  s_axi_awready,
    output logic [DATA_WIDTH-1:0]     s_axi_wdata = '0,
    output logic [DATA_WIDTH/8-1:0]   s_axi_wstrb = '0,
    output logic                      s_axi_wvalid = 1'b0,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    output logic                      s_axi_bready = 1'b0,
    // Read channels
    output logic [ADDR_WIDTH-1:0]     s_axi_araddr = '0,
    output logic                      s_axi_arvalid = 1'b0,
    input wire logic                  s_axi_arready,
    input wire logic [DATA_WIDTH-1:0] s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    output logic                      s_axi_rready = 1'b0
);
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(a_ok && w_ok))
        begin
            @(posedge clk);
            a_ok |= s_axi_awready;
            w_ok |= s_axi_wready;
            if (a_ok)
                s_axi_awvalid <= 1'b0;
            if (w_ok)
                s_axi_wvalid <= 1'b0;
        end
        // Released payload must not look valid
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        s_axi_bready <= 1'b1;
        do
            @(posedge clk);
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge clk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do
            @(posedge clk);
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

// [test/gph_config_tail_tb_top.sv]
// Testbench for the configuration header tail register bank
`timescale 1ns/1ps
module gph_config_tail_tb_top
    import gph_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic [ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]            s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [DATA_WIDTH-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int                    n_fail = 0;
    int                    compares = 0;
    logic [11:0]           ad [10] = '{12'h0b0, 12'h0b8, 12'h0c0, 12'h0d0, 12'h0f0, 12'h0f4, 12'h0f8, 12'h0fc,
                                       12'h370, 12'h378};
    logic [31:0]           rv [10] = '{32'h0, 32'h0, 32'h0, 32'hdc, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1, 32'h21};
    logic [31:0]           ev [10];
    logic                  lk [2];
    gph_config_tail uut (.*);
    gph_axi_master  host (.*);
    always #2.5 clk = ~clk;
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t resp %b expected %b", $time, got, exp);
        end
    endtask
    function automatic void mdl(int i, logic [31:0] d, logic [3:0] s);
        if (i < 2 && !lk[i] && |s[1:0])
        begin
            if (s[0])
                ev[i][7:0] = d[7:0];
            if (s[1])
                ev[i][15:8] = d[15:8];
            lk[i] = 1'b1;
        end
        if (i == 4 && s[0])
            ev[4] = {24'h0, d[7:0]};
    endfunction
    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        ev = rv;
        lk = '{1'b0, 1'b0};
    endtask
    task automatic check_all;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 10; i++)
        begin
            host.rd(ad[i], d, r);
            chk2(r, RESP_OKAY);
            chk32(d, ev[i]);
        end
    endtask
    task automatic run_pass(input int k);
        logic [31:0] d;
        logic [3:0]  s;
        logic [1:0]  r;
        for (int i = 0; i < 10; i++)
        begin
            d = $urandom;
            s = (k == 0) ? 4'hc : (k == 1) ? 4'h1 : 4'($urandom);
            host.wr(ad[i], d, s, r);
            chk2(r, RESP_OKAY);
            mdl(i, d, s);
        end
        check_all();
    endtask
    task automatic close_out;
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        void'($urandom(32'heb82d6b9));
        do_reset(8);
        check_all();
        for (int k = 0; k < 6; k++)
            run_pass(k);
        host.wr(12'h004, 32'hffffffff, 4'hf, r);
        chk2(r, RESP_SLVERR);
        host.rd(12'h004, d, r);
        chk2(r, RESP_SLVERR);
        chk32(d, 32'h0);
        do_reset(2);
        check_all();
        run_pass(6);
        run_pass(7);
        close_out();
    end
    initial
    begin
        #100us;
        n_fail++;
        close_out();
    end
endmodule

bind gph_config_tail gph_config_tail_asserts chk (.*);
